// *** hdl/pllc_top.sv ***
// pll and low-power rc clock control top
`timescale 1ns/1ps
`default_nettype none
module pllc_top #(
  parameter int LOCK_CYCLES = pllc_pkg::LOCK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  // config word two
  input  wire logic [2:0]                   cfg_pll_idiv,
  input  wire logic [2:0]                   cfg_pll_mult,
  input  wire logic [2:0]                   cfg_pll_odiv,
  // straps and enables
  input  wire logic                         vreg_en,
  input  wire logic                         failsafe_mon_en,
  input  wire logic                         watchdog_en,
  // oscillator state
  input  wire logic [2:0]                   current_osc_select,
  input  wire logic [1:0]                   posc_mode,
  input  wire logic [pllc_pkg::TRIM_W-1:0]  factory_cal,
  // asynchronous status
  input  wire logic                         pwrup_tmr_done_a,
  input  wire logic                         pll_lock_a,
  // software writes
  input  wire logic                         sw_unlock,
  input  wire logic                         tune_wr,
  input  wire logic [pllc_pkg::TUNE_W-1:0]  tune_wdata,
  input  wire logic                         pll_wr,
  input  wire logic [2:0]                   pll_wr_mult,
  input  wire logic [2:0]                   pll_wr_odiv,
  // fast rc trim
  output logic [pllc_pkg::TUNE_W-1:0]       fast_rc_tuning_reg,
  output logic [pllc_pkg::TRIM_W-1:0]       fast_rc_trim,
  // low-power rc
  output logic                              lowpwr_rc_en,
  // pll setup
  output logic [2:0]                        pll_multiplier_code,
  output logic [2:0]                        pll_output_divider,
  output logic [4:0]                        pll_mult_factor,
  output logic [8:0]                        pll_div_factor,
  output logic [2:0]                        pll_idiv_code,
  output logic                              pll_ref_fast_rc,
  output logic                              pll_ref_valid,
  // status
  output logic                              pll_lock_status,
  output logic [31:0]                       oscillator_control_reg
);
  import pllc_pkg::*;

  function automatic logic [4:0] mult_of(input logic [2:0] c);
    mult_of = (c == 3'h7) ? 5'h18 : 5'(5'h0f + {2'h0, c});
  endfunction

  function automatic logic [8:0] div_of(input logic [2:0] c);
    div_of = (c == 3'h7) ? 9'h100 : 9'(9'h001 << c);
  endfunction

  // two-flop synchronisers for timer and lock
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
    end else begin
      meta_q <= {pll_lock_a, pwrup_tmr_done_a};
      sync_q <= meta_q;
    end
  end
  wire pwrup_done = sync_q[0];

  // fast rc tuning guard
  logic              armed_q;
  logic [TUNE_W-1:0] tune_q;
  wire               tune_take = tune_wr && armed_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= sw_unlock || (armed_q && !tune_wr && !pll_wr);
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tune_q <= TUNE_RST;
    end else if (tune_take) begin
      tune_q <= tune_wdata;
    end
  end
  // signed step added to factory calibration; wraps if software pushes past range
  wire [TRIM_W-1:0] trim_d = factory_cal + {{(TRIM_W-TUNE_W){tune_q[TUNE_W-1]}}, tune_q};
  logic [TRIM_W-1:0] trim_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trim_q <= '0;
    end else begin
      trim_q <= trim_d;
    end
  end

  // low-power rc on/off
  pllc_lp_st_t st_q;
  logic        lp_en_q;
  wire         keep_alive = failsafe_mon_en || watchdog_en ||
                            (current_osc_select == OSC_LOWPWR_RC);
  wire         lp_en_d = (st_q == pllc_st_pwrup) ? vreg_en : keep_alive;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= pllc_st_pwrup;
    end else begin
      case (st_q)
        pllc_st_pwrup: begin
          if (pwrup_done) begin
            st_q <= pllc_st_run;
          end
        end
        pllc_st_run: st_q <= pllc_st_run;
        default:     st_q <= pllc_st_pwrup;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lp_en_q <= 1'b0;
    end else begin
      lp_en_q <= lp_en_d;
    end
  end

  // pll divider and multiplier fields, loaded from config word after each reset
  logic       load_q;
  logic [2:0] mult_q;
  logic [2:0] odiv_q;
  logic [2:0] idiv_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mult_q <= MULT_RST;
      odiv_q <= ODIV_RST;
    end else if (load_q) begin
      mult_q <= cfg_pll_mult;
      odiv_q <= cfg_pll_odiv;
    end else if (pll_wr) begin
      mult_q <= pll_wr_mult;
      odiv_q <= pll_wr_odiv;
    end
  end
  // no software path reaches the input divider
  wire [2:0] idiv_d = (current_osc_select == OSC_FASTRC_PLL) ? IDIV_DIV2 : cfg_pll_idiv;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idiv_q <= IDIV_RST;
    end else begin
      idiv_q <= idiv_d;
    end
  end

  // reference selection
  wire posc_ok   = (posc_mode == POSC_EC) || (posc_mode == POSC_XT) ||
                   (posc_mode == POSC_HS);
  wire use_fast  = (current_osc_select == OSC_FASTRC_PLL);
  wire use_posc  = (current_osc_select == OSC_POSC_PLL);
  wire ref_ok_d  = use_fast || (use_posc && posc_ok);
  logic ref_fast_q;
  logic ref_ok_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_fast_q <= 1'b0;
      ref_ok_q   <= 1'b0;
    end else begin
      ref_fast_q <= use_fast;
      ref_ok_q   <= ref_ok_d;
    end
  end

  // lock tracking: any change of the selected source restarts it
  logic [2:0] osc_prev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_prev_q <= OSC_RST;
    end else begin
      osc_prev_q <= current_osc_select;
    end
  end
  pllc_lock_if lk_if ();
  assign lk_if.restart  = (osc_prev_q != current_osc_select);
  assign lk_if.pll_used = use_fast || use_posc;
  assign lk_if.lock_raw = sync_q[1];

  pllc_lock #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .lk      (lk_if.tracker)
  );

  // outputs
  assign fast_rc_tuning_reg  = tune_q;
  assign fast_rc_trim        = trim_q;
  assign lowpwr_rc_en        = lp_en_q;
  assign pll_multiplier_code = mult_q;
  assign pll_output_divider  = odiv_q;
  assign pll_mult_factor     = mult_of(mult_q);
  assign pll_div_factor      = div_of(odiv_q);
  assign pll_idiv_code       = idiv_q;
  assign pll_ref_fast_rc     = ref_fast_q;
  assign pll_ref_valid       = ref_ok_q;
  assign pll_lock_status     = lk_if.lock;
  always_comb begin
    oscillator_control_reg = 32'h0000_0000;
    oscillator_control_reg[ODIV_LSB +: 3] = odiv_q;
    oscillator_control_reg[MULT_LSB +: 3] = mult_q;
    oscillator_control_reg[OSC_LSB +: 3]  = osc_prev_q;
    oscillator_control_reg[LOCK_BIT]      = lk_if.lock;
  end

  a_tune_guard: assert property (@(posedge ref_clk) disable iff (!nrst)
    tune_wr && !armed_q |=> $stable(fast_rc_tuning_reg))
    else $error("tuning written without unlock");
  a_tune_take: assert property (@(posedge ref_clk) disable iff (!nrst)
    sw_unlock ##1 tune_wr |=> fast_rc_tuning_reg == $past(tune_wdata))
    else $error("unlocked tuning write lost");
  a_cfg_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    load_q |=> pll_multiplier_code == $past(cfg_pll_mult) &&
               pll_output_divider == $past(cfg_pll_odiv))
    else $error("config defaults not loaded");
  a_idiv_force: assert property (@(posedge ref_clk) disable iff (!nrst)
    current_osc_select == OSC_FASTRC_PLL |=> pll_idiv_code == IDIV_DIV2)
    else $error("input divider not forced to two");
  a_lp_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_q == pllc_st_run && watchdog_en |=> lowpwr_rc_en)
    else $error("low-power rc dropped while kept alive");
  a_lp_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_q == pllc_st_run && !keep_alive |=> !lowpwr_rc_en)
    else $error("low-power rc left on");
  a_lp_pwrup: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_q == pllc_st_pwrup && vreg_en |=> lowpwr_rc_en)
    else $error("low-power rc off during power-up");
  a_ratio_map: assert property (@(posedge ref_clk) disable iff (!nrst)
    pll_output_divider == 3'h3 |-> pll_div_factor == 9'h008)
    else $error("divider code 011 not divide by eight");
  a_lock_gone: assert property (@(posedge ref_clk) disable iff (!nrst)
    !use_fast && !use_posc ##1 !use_fast && !use_posc |-> !pll_lock_status)
    else $error("lock status set with non-pll source");

endmodule
`default_nettype wire

// *** hdl/pllc_pkg.sv ***
// constants, codes and types for the pll and low-power rc clock control block
// Operation
// - Tuning register writes are ignored unless the unlock was performed just before; here an unlock stays armed until the next tuning or pll write.
// - Each tuning step moves the fast rc away from factory calibration by one increment.
// - At power-on the low-power rc runs whenever the voltage regulator is enabled.
// - After power-up timer expiry it stays on for monitor, watchdog or select 100.
// - With no keep-alive condition the low-power rc is turned off after expiry.
// - Pll reference is the XT, HS or EC primary oscillator, or the fast rc.
// - Every reset copies multiplier and output divider defaults from config word two.
// - Pll input divider comes from the config word, or is forced to two in fast rc with pll mode, never from software.
// - Software can rewrite multiplier and output divider at run time.
// - Lock status bit five is driven low whenever the pll input clock changes.
// - Lock status sets on pll lock or on timer expiry, even without real lock.
// - Lock status clears at power-on reset and on switches to a pll source.
// - Lock status stays clear while a source without the pll is selected.
// - Lock status need not fall on lost lock; it holds until a clearing event.
// - Multiplier codes give 15..21,24; divider codes 000..011 give 1,2,4,8.
// - Output divider sits in bits 29:27 and is selectable at run time.
// - In fast rc with pll mode the input divider is forced to two.
// - Current oscillator select sits in bits 14:12.
`default_nettype none
package pllc_pkg;

  localparam int          TUNE_W        = 6;
  localparam int          TRIM_W        = 8;
  localparam logic [5:0]  TUNE_RST      = 6'h00;
  localparam logic [2:0]  MULT_RST      = 3'h0;
  localparam logic [2:0]  ODIV_RST      = 3'h0;
  localparam logic [2:0]  IDIV_RST      = 3'h0;
  localparam logic [2:0]  OSC_RST       = 3'h0;

  // current oscillator select codes
  localparam logic [2:0]  OSC_FASTRC_PLL = 3'h1;
  localparam logic [2:0]  OSC_POSC_PLL   = 3'h3;
  localparam logic [2:0]  OSC_LOWPWR_RC  = 3'h4;

  // primary oscillator modes
  localparam logic [1:0]  POSC_EC       = 2'h0;
  localparam logic [1:0]  POSC_XT       = 2'h1;
  localparam logic [1:0]  POSC_HS       = 2'h2;

  // input divider code that divides by two
  localparam logic [2:0]  IDIV_DIV2     = 3'h1;

  // control word field positions
  localparam int          ODIV_LSB      = 27;
  localparam int          MULT_LSB      = 16;
  localparam int          OSC_LSB       = 12;
  localparam int          LOCK_BIT      = 5;

  // lock timeout in reference clock cycles
  localparam int          LOCK_CYCLES_DEF = 2000;

  typedef enum logic {
    pllc_st_pwrup,
    pllc_st_run
  } pllc_lp_st_t;

endpackage
`default_nettype wire

// *** hdl/pllc_lock_if.sv ***
// carrier between the control top and the lock tracker
`timescale 1ns/1ps
`default_nettype none
interface pllc_lock_if;
  logic restart;
  logic pll_used;
  logic lock_raw;
  logic lock;
  modport tracker (input restart, input pll_used, input lock_raw, output lock);
  modport ctrl    (output restart, output pll_used, output lock_raw, input lock);
endinterface
`default_nettype wire

// *** hdl/pllc_lock.sv ***
// pll lock status tracker with start-up timeout
`timescale 1ns/1ps
`default_nettype none
module pllc_lock #(
  parameter int LOCK_CYCLES = pllc_pkg::LOCK_CYCLES_DEF
) (
  // clock and reset
  input wire logic     ref_clk,
  input wire logic     nrst,
  // lock handshake
  pllc_lock_if.tracker lk
);
  import pllc_pkg::*;

  localparam int CW = $clog2(LOCK_CYCLES + 1);

  logic [CW-1:0] count_q;
  logic          lock_q;
  wire           timeout = (count_q == CW'(LOCK_CYCLES));
  wire           clr     = lk.restart || !lk.pll_used;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (clr) begin
      count_q <= '0;
    end else if (!timeout) begin
      count_q <= count_q + 1'b1;
    end
  end

  // a clearing event beats a same-cycle lock report: the input clock just changed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= 1'b0;
    end else if (clr) begin
      lock_q <= 1'b0;
    end else if (lk.lock_raw || timeout) begin
      lock_q <= 1'b1;
    end
  end

  assign lk.lock = lock_q;

  a_lock_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    clr |=> !lk.lock) else $error("lock status not cleared");
  a_lock_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    lk.lock && !clr |=> lk.lock) else $error("lock status dropped without cause");
  a_lock_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(lk.lock) |-> $past(lk.lock_raw) || $past(timeout))
    else $error("lock status set without cause");

endmodule
`default_nettype wire

// *** bench/pllc_osc_model.sv ***
// oscillator sources and config word two storage seen by the clock control
`timescale 1ns/1ps
`default_nettype none
module pllc_osc_model #(
  parameter logic [2:0] IDIV = 3'h3,
  parameter logic [2:0] MULT = 3'h5,
  parameter logic [2:0] ODIV = 3'h2,
  parameter logic [7:0] CAL  = 8'h80
) (
  // requests from the bench
  input  wire logic       expire,
  input  wire logic       lock_req,
  // towards the block
  output logic [2:0]      cfg_idiv,
  output logic [2:0]      cfg_mult,
  output logic [2:0]      cfg_odiv,
  output logic [7:0]      cal,
  output logic            tmr_done,
  output logic            lock
);
  // idiv 011 stands for divide-by-4 here: a 16 MHz crystal gives 4 MHz at the pll input
  assign cfg_idiv = IDIV;
  // mult 20, odiv 4 keeps the output well under the device maximum
  assign cfg_mult = MULT;
  assign cfg_odiv = ODIV;
  assign cal      = CAL;
  // analog status lands between clock edges, never on one, so sampling is not a race
  assign #2 tmr_done = expire;
  assign #2 lock     = lock_req;
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the pll and low-power rc clock control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pllc_pkg::*;
  localparam int LK = 8;
  localparam logic [2:0] IDIV_C = 3'h3;
  localparam logic [2:0] MULT_C = 3'h5;
  localparam logic [2:0] ODIV_C = 3'h2;
  localparam int MF[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  localparam int DF[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic vreg_en = 1'b1;
  logic fsm_en = 1'b0;
  logic wdt_en = 1'b0;
  logic [2:0] osc = 3'h0;
  logic [1:0] posc = POSC_XT;
  logic unlock = 1'b0;
  logic tune_wr = 1'b0;
  logic [5:0] tune_d = 6'h00;
  logic pll_wr = 1'b0;
  logic [2:0] wr_m = 3'h0;
  logic [2:0] wr_o = 3'h0;
  logic expire = 1'b0;
  logic lock_req = 1'b0;
  wire logic [2:0] c_idiv, c_mult, c_odiv, mcode, odiv, idiv;
  wire logic [7:0] cal, trim;
  wire logic [5:0] tuning;
  wire logic [4:0] mfac;
  wire logic [8:0] dfac;
  wire logic [31:0] ocr;
  wire logic tmr_done, lock_a, lp_en, ref_frc, ref_ok, lock_st;
  int n_errors = 0;
  int checks = 0;

  always #2 ref_clk = ~ref_clk;

  pllc_osc_model #(.IDIV(IDIV_C), .MULT(MULT_C), .ODIV(ODIV_C), .CAL(8'h80)) osc_src (
    .expire(expire), .lock_req(lock_req), .cfg_idiv(c_idiv), .cfg_mult(c_mult),
    .cfg_odiv(c_odiv), .cal(cal), .tmr_done(tmr_done), .lock(lock_a));

  pllc_top #(.LOCK_CYCLES(LK)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .cfg_pll_idiv(c_idiv), .cfg_pll_mult(c_mult),
    .cfg_pll_odiv(c_odiv), .vreg_en(vreg_en), .failsafe_mon_en(fsm_en),
    .watchdog_en(wdt_en), .current_osc_select(osc), .posc_mode(posc), .factory_cal(cal),
    .pwrup_tmr_done_a(tmr_done), .pll_lock_a(lock_a), .sw_unlock(unlock),
    .tune_wr(tune_wr), .tune_wdata(tune_d), .pll_wr(pll_wr), .pll_wr_mult(wr_m),
    .pll_wr_odiv(wr_o), .fast_rc_tuning_reg(tuning), .fast_rc_trim(trim),
    .lowpwr_rc_en(lp_en), .pll_multiplier_code(mcode), .pll_output_divider(odiv),
    .pll_mult_factor(mfac), .pll_div_factor(dfac), .pll_idiv_code(idiv),
    .pll_ref_fast_rc(ref_frc), .pll_ref_valid(ref_ok), .pll_lock_status(lock_st),
    .oscillator_control_reg(ocr));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // strobe is dropped a full cycle before the next write may raise it
  task automatic wr_pll(input logic [2:0] m, input logic [2:0] o);
    wr_m = m;
    wr_o = o;
    pll_wr = 1'b1;
    tick(1);
    pll_wr = 1'b0;
    tick(1);
  endtask

  task automatic tune(input logic arm, input logic [5:0] d);
    tune_d = d;
    unlock = arm;
    tick(1);
    unlock = 1'b0;
    tune_wr = 1'b1;
    tick(1);
    tune_wr = 1'b0;
    tick(2);
  endtask

  task automatic t_defaults;
    chk("mult code", MULT_C, mcode);
    chk("odiv code", ODIV_C, odiv);
    chk("mult factor", 20, mfac);
    chk("div factor", 4, dfac);
    chk("readback odiv", ODIV_C, ocr[29:27]);
    chk("readback osc", 0, ocr[14:12]);
    chk("idiv", IDIV_C, idiv);
    chk("lock at por", 0, lock_st);
    chk("low_power_internal_rc at por", 1, lp_en);
    vreg_en = 1'b0;
    tick(3);
    chk("low_power_internal_rc no vreg", 0, lp_en);
    vreg_en = 1'b1;
    tick(3);
    $display("test defaults done");
  endtask

  task automatic t_tune;
    tune(1'b0, 6'h3e);
    chk("tune guarded", 0, tuning);
    tune(1'b1, 6'h3e);
    chk("tune value", 6'h3e, tuning);
    chk("trim down", 8'h7e, trim);
    unlock = 1'b1;
    tick(1);
    unlock = 1'b0;
    wr_pll(MULT_C, ODIV_C);
    tune(1'b0, 6'h05);
    chk("tune disarmed", 6'h3e, tuning);
    tune(1'b1, 6'h05);
    chk("trim up", 8'h85, trim);
    $display("test tune done");
  endtask

  task automatic t_pll;
    for (int i = 0; i < 8; i++) begin
      wr_pll(i[2:0], i[2:0]);
      chk("mult code", i[2:0], mcode);
      chk("readback mult", i[2:0], ocr[18:16]);
      chk("mult factor", MF[i], mfac);
      chk("div factor", DF[i], dfac);
      chk("readback odiv", i[2:0], ocr[29:27]);
      chk("idiv fixed", IDIV_C, idiv);
    end
    $display("test pll done");
  endtask

  task automatic t_low_power_internal_rc;
    tick(4);
    chk("low_power_internal_rc before expiry", 1, lp_en);
    expire = 1'b1;
    tick(8);
    for (int k = 0; k < 4; k++) begin
      fsm_en = (k == 0);
      wdt_en = (k == 1);
      osc = (k == 2) ? OSC_LOWPWR_RC : 3'h0;
      tick(3);
      chk("low_power_internal_rc keep alive", k < 3, lp_en);
    end
    $display("test low_power_internal_rc done");
  endtask

  task automatic t_lock;
    lock_req = 1'b1;
    tick(8);
    chk("lock non-pll", 0, lock_st);
    lock_req = 1'b0;
    tick(6);
    osc = OSC_POSC_PLL;
    tick(LK + 1);
    chk("lock early", 0, lock_st);
    tick(1);
    chk("lock timeout", 1, lock_st);
    chk("readback lock", 1, ocr[LOCK_BIT]);
    chk("readback osc", OSC_POSC_PLL, ocr[14:12]);
    chk("posc ref not fast", 0, ref_frc);
    for (int p = 0; p < 4; p++) begin
      posc = p[1:0];
      tick(3);
      chk("posc reference", p != 3, ref_ok);
    end
    posc = POSC_XT;
    osc = 3'h0;
    tick(2);
    chk("lock off non-pll", 0, lock_st);
    lock_req = 1'b1;
    tick(6);
    osc = OSC_FASTRC_PLL;
    tick(5);
    chk("lock on pll lock", 1, lock_st);
    chk("idiv forced", IDIV_DIV2, idiv);
    chk("fast rc ref", 1, ref_frc);
    chk("fast rc ok", 1, ref_ok);
    lock_req = 1'b0;
    tick(12);
    chk("lock held", 1, lock_st);
    osc = OSC_POSC_PLL;
    tick(2);
    chk("lock switch clear", 0, lock_st);
    $display("test lock done");
  endtask

  task automatic t_rerst;
    wr_pll(3'h7, 3'h3);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(3);
    chk("mult reload", MULT_C, mcode);
    chk("odiv reload", ODIV_C, odiv);
    chk("lock after reset", 0, lock_st);
    $display("test rereset done");
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    tick(16);
    nrst = 1'b1;
    tick(2);
    t_defaults();
    t_tune();
    t_pll();
    t_low_power_internal_rc();
    t_lock();
    t_rerst();
    complete_run();
  end

  // whole sequence is about 150 cycles
  initial begin
    #(5000 * 4);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
